// [seg_decode_pkg.sv]
// Purpose: constants and carriers for the segment select and opcode decode block
// Assumes: one core clock, opcodes arrive one byte per issue
// Notes: opcode values follow the classic one-byte encoding
package seg_decode_pkg;
    localparam logic [7:0] OP_PFX_EXTRA = 8'h26;
    localparam logic [7:0] OP_PFX_CODE = 8'h2E;
    localparam logic [7:0] OP_PFX_STACK = 8'h36;
    localparam logic [7:0] OP_PFX_DATA = 8'h3E;
    localparam logic [7:0] OP_PFX_LOCK = 8'hF0;
    localparam logic [7:0] OP_PFX_REP_NE = 8'hF2;
    localparam logic [7:0] OP_PFX_REP = 8'hF3;
    localparam logic [7:0] OP_PUSH_ALL = 8'h60;
    localparam logic [7:0] OP_POP_ALL = 8'h61;
    localparam logic [7:0] OP_BOUND = 8'h62;
    localparam logic [7:0] OP_ENTER = 8'hC8;
    localparam logic [7:0] OP_LEAVE = 8'hC9;
    localparam logic [7:0] OP_FAR_EXTRA = 8'hC4;
    localparam logic [7:0] OP_FAR_DATA = 8'hC5;
    localparam logic [7:0] OP_BYTE_WIDEN = 8'h98;
    localparam logic [7:0] OP_WORD_WIDEN = 8'h99;
    localparam logic [7:0] OP_WAIT = 8'h9B;
    localparam logic [7:0] OP_PUSH_FLAGS = 8'h9C;
    localparam logic [7:0] OP_POP_FLAGS = 8'h9D;
    localparam logic [7:0] OP_ACC_TO_FLAGS = 8'h9E;
    localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h9F;
    localparam logic [7:0] OP_TRAP_OVF = 8'hCE;
    localparam logic [7:0] OP_LOOP_NE = 8'hE0;
    localparam logic [7:0] OP_LOOP_EQ = 8'hE1;
    localparam logic [7:0] OP_LOOP = 8'hE2;
    localparam logic [7:0] OP_JUMP_CZ = 8'hE3;
    localparam logic [7:0] OP_HALT = 8'hF4;
    localparam logic [3:0] OP_JCC_HI = 4'h7;
    localparam logic [4:0] OP_ESC_HI = 5'h1B;
    localparam logic [4:0] OP_ADC_HI = 5'h02;
    localparam logic [4:0] OP_SBB_HI = 5'h03;
    localparam logic [1:0] OP_ALU_IMM_ACC = 2'h3;
    localparam logic [5:0] STR_MOVE_CMP_HI = 6'h29;
    localparam logic [4:0] STR_STORE_HI = 5'h15;
    localparam logic [5:0] STR_PORT_HI = 6'h1B;
    localparam logic [3:0] STR_CMP_HI = 4'hA;
    localparam logic [1:0] STR_CMP_LO = 2'h3;
    localparam int FLAG_CF = 0;
    localparam int FLAG_PF = 2;
    localparam int FLAG_ZF = 6;
    localparam int FLAG_SF = 7;
    localparam int FLAG_OF = 11;
    localparam int SEG_SHIFT = 4;
    localparam logic [7:0] VEC_OVERFLOW = 8'h04;
    localparam logic [7:0] VEC_BOUNDS = 8'h05;
    typedef enum logic [1:0] {SEG_EXTRA = 2'h0, SEG_CODE = 2'h1, SEG_STACK = 2'h2,
        SEG_DATA = 2'h3} seg_t;
    typedef enum logic [2:0] {ACC_FETCH = 3'h0, ACC_IMM = 3'h1, ACC_DATA = 3'h2,
        ACC_STACK = 3'h3, ACC_STR_DST = 3'h4} acc_t;
    typedef enum logic [1:0] {RPT_NONE = 2'h0, RPT_EQ = 2'h1, RPT_NE = 2'h2} rpt_t;
    typedef enum logic [3:0] {CL_NONE, CL_PUSH_ALL, CL_POP_ALL, CL_ENTER, CL_LEAVE,
        CL_FAR_PTR, CL_FLAGS_TO_ACC, CL_ACC_TO_FLAGS, CL_PUSH_FLAGS, CL_POP_FLAGS,
        CL_ARITH_CARRY, CL_WIDEN, CL_STRING, CL_BRANCH, CL_ESCAPE, CL_TRAP_CHECK} class_t;
    typedef struct packed {logic valid; logic [7:0] opcode;} dec_in_t;
    typedef struct packed {
        logic valid;
        acc_t kind;
        logic [15:0] base;
        logic [15:0] index;
        logic [15:0] disp;
        logic use_base;
        logic use_index;
        logic base_is_bp;
        logic disp8;
    } mem_req_t;
    typedef struct packed {logic [15:0] extra, code, stack, data;} seg_file_t;
    typedef struct packed {logic [15:0] a, b;} alu_in_t;
    typedef struct packed {logic [15:0] index, lower, upper;} bound_t;
    typedef struct packed {logic we; logic [15:0] data; logic [15:0] aux; logic carry;} result_t;
endpackage

// [segment_select_opcode_decode.sv]
// Purpose: default segment choice, address forming and opcode class decode
// Assumes: the executor sequences multi-cycle classes that this block flags
// Notes: prefixes collect until the next non-prefix opcode issues
`timescale 1ns/1ps
module segment_select_opcode_decode (
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire seg_decode_pkg::dec_in_t I_DEC,
    input wire seg_decode_pkg::mem_req_t I_MEM,
    input wire seg_decode_pkg::seg_file_t I_SEG,
    input wire seg_decode_pkg::alu_in_t I_ALU,
    input wire seg_decode_pkg::bound_t I_BOUND,
    input wire logic [15:0] I_FLAGS,
    input wire logic [15:0] I_COUNT,
    input wire logic [15:0] I_ACCUM,
    input wire logic I_INTR,
    input wire logic I_TEST_N,
    output logic O_STALL,
    output seg_decode_pkg::seg_t O_SEG_SEL,
    output logic [19:0] O_PHYS_ADDR,
    output logic O_ADDR_VALID,
    output seg_decode_pkg::class_t O_CLASS,
    output seg_decode_pkg::seg_t O_FAR_SEG,
    output seg_decode_pkg::result_t O_RESULT,
    output logic O_BRANCH,
    output logic [15:0] O_COUNT_NEXT,
    output logic O_COUNT_WE,
    output logic O_REP_AGAIN,
    output logic O_STR_ELEM,
    output logic O_HALTED,
    output logic O_LOCK_N,
    output logic O_ESC,
    output logic O_TRAP,
    output logic [7:0] O_TRAP_VEC
);
    import seg_decode_pkg::*;

    typedef enum logic [2:0] {ST_RUN = 3'h1, ST_HALT = 3'h2, ST_WAIT = 3'h4} state_t;

    state_t state;
    logic [7:0] op;
    logic issue, is_prefix, is_string, is_cmp_str, zf, cf;
    logic [2:0] test_sync;
    logic test_active;
    logic pend_seg_valid, cur_seg_valid, pend_lock, cur_lock;
    seg_t pend_seg, cur_seg, next_seg;
    rpt_t pend_rep;
    logic [15:0] next_count, disp_ext, ea, seg_val;
    logic [19:0] next_phys;
    logic cond, next_branch, next_count_we, next_rep_again, next_elem;
    logic [16:0] sum_w, dif_w;
    logic [8:0] sum_b, dif_b;

    // the top bit of each sum is the carry or borrow out
    assign sum_w = 17'(I_ALU.a) + 17'(I_ALU.b) + 17'(cf);
    assign dif_w = 17'(I_ALU.a) - 17'(I_ALU.b) - 17'(cf);
    assign sum_b = 9'(I_ALU.a[7:0]) + 9'(I_ALU.b[7:0]) + 9'(cf);
    assign dif_b = 9'(I_ALU.a[7:0]) - 9'(I_ALU.b[7:0]) - 9'(cf);

    assign op = I_DEC.opcode;
    assign O_STALL = (state != ST_RUN);
    assign issue = I_DEC.valid && !O_STALL;
    assign O_HALTED = (state == ST_HALT);
    assign O_LOCK_N = !cur_lock;
    assign zf = I_FLAGS[FLAG_ZF];
    assign cf = I_FLAGS[FLAG_CF];
    assign is_prefix = (op == OP_PFX_EXTRA) || (op == OP_PFX_CODE) || (op == OP_PFX_STACK)
        || (op == OP_PFX_DATA) || (op == OP_PFX_LOCK) || (op == OP_PFX_REP)
        || (op == OP_PFX_REP_NE);
    assign is_string = (op[7:2] == STR_MOVE_CMP_HI) || (op[7:2] == STR_PORT_HI)
        || ((op[7:3] == STR_STORE_HI) && (op[2:1] != 2'h0));
    assign is_cmp_str = (op[7:4] == STR_CMP_HI) && (op[2:1] == STR_CMP_LO);

    ////////////////////////////////////////////////////////////////////////////////
    // test pin: three stages, level accepted once the last two agree
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            test_sync <= 3'h7;
            test_active <= 1'b0;
        end else begin
            test_sync <= {test_sync[1:0], I_TEST_N};
            if (test_sync[1] == test_sync[2]) begin
                test_active <= !test_sync[2];
            end
        end
    end

    // run, halt and wait; only reset or an interrupt leaves halt
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state <= ST_RUN;
        end else begin
            case (state)
                ST_RUN: begin
                    if (issue && op == OP_HALT) begin
                        state <= ST_HALT;
                    end else if (issue && op == OP_WAIT && !test_active) begin
                        state <= ST_WAIT;
                    end
                end
                ST_HALT: begin
                    if (I_INTR) begin
                        state <= ST_RUN;
                    end
                end
                ST_WAIT: begin
                    if (test_active) begin
                        state <= ST_RUN;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // prefixes gather, then belong to the instruction that follows them;
    // a repeating string keeps them so the re-issued element sees them again
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pend_seg_valid <= 1'b0;
            pend_seg <= SEG_DATA;
            pend_lock <= 1'b0;
            pend_rep <= RPT_NONE;
            cur_seg_valid <= 1'b0;
            cur_seg <= SEG_DATA;
            cur_lock <= 1'b0;
        end else if (issue) begin
            case (op)
                OP_PFX_EXTRA: {pend_seg_valid, pend_seg} <= {1'b1, SEG_EXTRA};
                OP_PFX_CODE: {pend_seg_valid, pend_seg} <= {1'b1, SEG_CODE};
                OP_PFX_STACK: {pend_seg_valid, pend_seg} <= {1'b1, SEG_STACK};
                OP_PFX_DATA: {pend_seg_valid, pend_seg} <= {1'b1, SEG_DATA};
                OP_PFX_LOCK: pend_lock <= 1'b1;
                OP_PFX_REP: pend_rep <= RPT_EQ;
                OP_PFX_REP_NE: pend_rep <= RPT_NE;
                default: begin
                    cur_seg_valid <= pend_seg_valid;
                    cur_seg <= pend_seg;
                    cur_lock <= pend_lock;
                    if (!next_rep_again) begin
                        pend_seg_valid <= 1'b0;
                        pend_lock <= 1'b0;
                        pend_rep <= RPT_NONE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // segment choice and address forming
    always_comb begin
        case (I_MEM.kind)
            ACC_FETCH, ACC_IMM: next_seg = SEG_CODE;
            ACC_STACK: next_seg = SEG_STACK;
            ACC_STR_DST: next_seg = SEG_EXTRA;
            default: begin
                if (cur_seg_valid) begin
                    next_seg = cur_seg;
                end else if (I_MEM.use_base && I_MEM.base_is_bp) begin
                    next_seg = SEG_STACK;
                end else begin
                    next_seg = SEG_DATA;
                end
            end
        endcase
        case (next_seg)
            SEG_EXTRA: seg_val = I_SEG.extra;
            SEG_CODE: seg_val = I_SEG.code;
            SEG_STACK: seg_val = I_SEG.stack;
            default: seg_val = I_SEG.data;
        endcase
        disp_ext = I_MEM.disp8 ? {{8{I_MEM.disp[7]}}, I_MEM.disp[7:0]} : I_MEM.disp;
        ea = (I_MEM.use_base ? I_MEM.base : 16'h0000)
            + (I_MEM.use_index ? I_MEM.index : 16'h0000) + disp_ext;
        next_phys = 20'({4'h0, seg_val} << SEG_SHIFT) + {4'h0, ea};
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SEG_SEL <= SEG_DATA;
            O_PHYS_ADDR <= 20'h00000;
            O_ADDR_VALID <= 1'b0;
        end else begin
            O_ADDR_VALID <= I_MEM.valid;
            if (I_MEM.valid) begin
                O_SEG_SEL <= next_seg;
                O_PHYS_ADDR <= next_phys;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // branch, loop and repeat decisions on the flags and the count register
    always_comb begin
        next_count = I_COUNT - 16'h0001;
        case (op[3:1])
            3'h0: cond = I_FLAGS[FLAG_OF];
            3'h1: cond = cf;
            3'h2: cond = zf;
            3'h3: cond = cf || zf;
            3'h4: cond = I_FLAGS[FLAG_SF];
            3'h5: cond = I_FLAGS[FLAG_PF];
            3'h6: cond = I_FLAGS[FLAG_SF] != I_FLAGS[FLAG_OF];
            default: cond = (I_FLAGS[FLAG_SF] != I_FLAGS[FLAG_OF]) || zf;
        endcase
        next_branch = 1'b0;
        next_count_we = 1'b0;
        next_rep_again = 1'b0;
        next_elem = 1'b0;
        if (op[7:4] == OP_JCC_HI) begin
            next_branch = cond ^ op[0];
        end else if (op == OP_JUMP_CZ) begin
            next_branch = (I_COUNT == 16'h0000);
        end else if (op == OP_LOOP || op == OP_LOOP_EQ || op == OP_LOOP_NE) begin
            next_count_we = 1'b1;
            next_branch = (next_count != 16'h0000) && ((op == OP_LOOP)
                || (op == OP_LOOP_EQ && zf) || (op == OP_LOOP_NE && !zf));
        end else if (is_string) begin
            if (pend_rep == RPT_NONE) begin
                next_elem = 1'b1;
            end else if (I_COUNT != 16'h0000) begin
                next_elem = 1'b1;
                next_count_we = 1'b1;
                next_rep_again = (next_count != 16'h0000) && (!is_cmp_str
                    || (pend_rep == RPT_EQ && zf) || (pend_rep == RPT_NE && !zf));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // class decode and one-cycle results
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CLASS <= CL_NONE;
            O_BRANCH <= 1'b0;
            O_COUNT_NEXT <= 16'h0000;
            O_COUNT_WE <= 1'b0;
            O_REP_AGAIN <= 1'b0;
            O_STR_ELEM <= 1'b0;
        end else begin
            O_CLASS <= CL_NONE;
            O_BRANCH <= 1'b0;
            O_COUNT_WE <= 1'b0;
            O_REP_AGAIN <= 1'b0;
            O_STR_ELEM <= 1'b0;
            if (issue && !is_prefix) begin
                O_BRANCH <= next_branch;
                O_COUNT_NEXT <= next_count;
                O_COUNT_WE <= next_count_we;
                O_REP_AGAIN <= next_rep_again;
                O_STR_ELEM <= next_elem;
                case (op)
                    OP_PUSH_ALL: O_CLASS <= CL_PUSH_ALL;
                    OP_POP_ALL: O_CLASS <= CL_POP_ALL;
                    OP_ENTER: O_CLASS <= CL_ENTER;
                    OP_LEAVE: O_CLASS <= CL_LEAVE;
                    OP_FAR_DATA, OP_FAR_EXTRA: O_CLASS <= CL_FAR_PTR;
                    OP_FLAGS_TO_ACC: O_CLASS <= CL_FLAGS_TO_ACC;
                    OP_ACC_TO_FLAGS: O_CLASS <= CL_ACC_TO_FLAGS;
                    OP_PUSH_FLAGS: O_CLASS <= CL_PUSH_FLAGS;
                    OP_POP_FLAGS: O_CLASS <= CL_POP_FLAGS;
                    OP_BYTE_WIDEN, OP_WORD_WIDEN: O_CLASS <= CL_WIDEN;
                    OP_BOUND, OP_TRAP_OVF: O_CLASS <= CL_TRAP_CHECK;
                    OP_LOOP, OP_LOOP_EQ, OP_LOOP_NE, OP_JUMP_CZ: O_CLASS <= CL_BRANCH;
                    default: begin
                        if (op[7:4] == OP_JCC_HI) begin
                            O_CLASS <= CL_BRANCH;
                        end else if (op[7:3] == OP_ESC_HI) begin
                            O_CLASS <= CL_ESCAPE;
                        end else if ((op[7:3] == OP_ADC_HI || op[7:3] == OP_SBB_HI)
                                && op[2:1] != OP_ALU_IMM_ACC) begin
                            O_CLASS <= CL_ARITH_CARRY;
                        end else if (is_string) begin
                            O_CLASS <= CL_STRING;
                        end
                    end
                endcase
            end
        end
    end

    // data paths; carry add and subtract take word operands when opcode bit zero is set
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RESULT <= '0;
            O_FAR_SEG <= SEG_DATA;
        end else begin
            O_RESULT.we <= 1'b0;
            if (issue) begin
                if (op == OP_FAR_DATA || op == OP_FAR_EXTRA) begin
                    O_FAR_SEG <= (op == OP_FAR_DATA) ? SEG_DATA : SEG_EXTRA;
                end else if (op == OP_FLAGS_TO_ACC) begin
                    O_RESULT <= {1'b1, I_FLAGS[7:0], I_ACCUM[7:0], I_FLAGS, cf};
                end else if (op == OP_ACC_TO_FLAGS) begin
                    O_RESULT <= {1'b1, I_ACCUM, I_FLAGS[15:8], I_ACCUM[15:8], I_ACCUM[8]};
                end else if (op == OP_BYTE_WIDEN) begin
                    O_RESULT <= {1'b1, {8{I_ACCUM[7]}}, I_ACCUM[7:0], 16'h0000, cf};
                end else if (op == OP_WORD_WIDEN) begin
                    O_RESULT <= {1'b1, I_ACCUM, {16{I_ACCUM[15]}}, cf};
                end else if (op[7:3] == OP_ADC_HI && op[2:1] != OP_ALU_IMM_ACC) begin
                    O_RESULT <= op[0] ? {1'b1, sum_w[15:0], 16'h0000, sum_w[16]}
                        : {1'b1, 8'h00, sum_b[7:0], 16'h0000, sum_b[8]};
                end else if (op[7:3] == OP_SBB_HI && op[2:1] != OP_ALU_IMM_ACC) begin
                    O_RESULT <= op[0] ? {1'b1, dif_w[15:0], 16'h0000, dif_w[16]}
                        : {1'b1, 8'h00, dif_b[7:0], 16'h0000, dif_b[8]};
                end
            end
        end
    end

    // escape hand-off and the two checking traps
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_ESC <= 1'b0;
            O_TRAP <= 1'b0;
            O_TRAP_VEC <= 8'h00;
        end else begin
            O_ESC <= issue && (op[7:3] == OP_ESC_HI);
            O_TRAP <= 1'b0;
            if (issue && op == OP_TRAP_OVF && I_FLAGS[FLAG_OF]) begin
                O_TRAP <= 1'b1;
                O_TRAP_VEC <= VEC_OVERFLOW;
            end else if (issue && op == OP_BOUND && (($signed(I_BOUND.index)
                    < $signed(I_BOUND.lower)) || ($signed(I_BOUND.index)
                    > $signed(I_BOUND.upper)))) begin
                O_TRAP <= 1'b1;
                O_TRAP_VEC <= VEC_BOUNDS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence s_wait_blocked;
        issue && op == OP_WAIT && !test_active;
    endsequence
    sequence s_lock_then_op;
        issue && op == OP_PFX_LOCK ##1 (!issue || is_prefix) ##1 issue && !is_prefix;
    endsequence

    AST_FETCH_CODE: assert property (I_MEM.valid && I_MEM.kind == ACC_FETCH |=> O_SEG_SEL == SEG_CODE) else $error("fetch not on code segment");
    AST_DATA_DEFAULT: assert property (I_MEM.valid && I_MEM.kind == ACC_DATA && !cur_seg_valid && !I_MEM.use_base |=> O_SEG_SEL == SEG_DATA) else $error("data default wrong");
    AST_STACK_SEG: assert property (I_MEM.valid && I_MEM.kind == ACC_STACK |=> O_SEG_SEL == SEG_STACK && O_ADDR_VALID) else $error("stack not on stack segment");
    AST_BP_STACK: assert property (I_MEM.valid && I_MEM.kind == ACC_DATA && I_MEM.use_base && I_MEM.base_is_bp && !cur_seg_valid |=> O_SEG_SEL == SEG_STACK) else $error("bp base not on stack");
    AST_STR_EXTRA: assert property (I_MEM.valid && I_MEM.kind == ACC_STR_DST |=> O_SEG_SEL == SEG_EXTRA) else $error("string destination not on extra");
    AST_HALT_HOLD: assert property (issue && op == OP_HALT ##1 !I_INTR [*3] |-> O_HALTED && O_STALL) else $error("halt released early");
    AST_WAIT_STALL: assert property (s_wait_blocked ##1 !test_active |-> O_STALL) else $error("wait did not stall");
    AST_WAIT_RELEASE: assert property (state == ST_WAIT && test_active |=> !O_STALL) else $error("wait not released");
    AST_LOCK_HELD: assert property (s_lock_then_op |=> !O_LOCK_N) else $error("bus not locked");
    AST_JUMP_CZ: assert property (issue && op == OP_JUMP_CZ |=> O_BRANCH == ($past(I_COUNT) == 16'h0000) && !O_COUNT_WE) else $error("count-zero jump wrong");
    AST_LOOP_DEC: assert property (issue && op == OP_LOOP |=> O_COUNT_WE && O_COUNT_NEXT == $past(I_COUNT) - 16'h0001 && O_BRANCH == ($past(I_COUNT) != 16'h0001)) else $error("loop count wrong");
    AST_TRAP_OVF: assert property (issue && op == OP_TRAP_OVF |=> O_TRAP == $past(I_FLAGS[FLAG_OF])) else $error("overflow trap wrong");
    AST_PHYS: assert property (I_MEM.valid && I_MEM.kind == ACC_FETCH && I_MEM.use_base && !I_MEM.use_index && I_MEM.disp == 16'h0000 |=> O_PHYS_ADDR == 20'({4'h0, $past(I_SEG.code)} << SEG_SHIFT) + {4'h0, $past(I_MEM.base)}) else $error("physical address wrong");
endmodule

// [test_pin_partner.sv]
// Purpose: coprocessor side that answers the wait test pin
// Assumes: pin is active low and idles high
// Notes: lag sets how slowly the pin answers a stalled core
`timescale 1ns/1ps
module test_pin_partner (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_stall,
    input wire logic [3:0] i_lag,
    output logic o_test_n
);
    logic [3:0] wait_cnt;
    // released as soon as the core moves on, so a stale low frees only a wait issued before the core's synchroniser drains
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_cnt <= 4'h0;
            o_test_n <= 1'h1;
        end else if (!i_stall) begin
            wait_cnt <= 4'h0;
            o_test_n <= 1'h1;
        end else if (wait_cnt == i_lag) begin
            o_test_n <= 1'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// [testbench.sv]
// Purpose: self-checking bench for segment select and opcode decode
// Assumes: inputs change on the falling edge, pulses are read one falling edge later
// Notes: a mid-run reset during halt closes the sequence
`timescale 1ns/1ps
module testbench;
    import seg_decode_pkg::*;
    `define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
        $display("FAIL %s exp %h got %h", n, e, g); end end
    typedef struct packed {logic [7:0] op; logic [15:0] cnt, flg; class_t cls; logic br, we;} row_t;
    logic clk = 1'h0, rst_n = 1'h0, intr = 1'h0, test_n;
    dec_in_t dec = '0;
    mem_req_t mem = '0;
    seg_file_t seg = '{16'h4000, 16'h3000, 16'h2000, 16'h1000};
    alu_in_t alu = '0;
    bound_t bnd = '0;
    logic [15:0] flags = '0, count = '0, accum = '0, cnext;
    int mismatches = 0, n_compared = 0, cycles = 0, n;
    logic stall, avalid, br, cwe, halted, lock_n, trap, extension_handoff, rep_again, str_elem;
    logic [19:0] paddr;
    logic [7:0] tvec;
    seg_t ssel, far_seg;
    class_t cls;
    result_t res;
    row_t rows [12] = '{'{8'hE3, 16'h0, 16'h0, CL_BRANCH, 1'h1, 1'h0},
        '{8'hE3, 16'h5, 16'h0, CL_BRANCH, 1'h0, 1'h0}, '{8'hE2, 16'h5, 16'h0, CL_BRANCH, 1'h1, 1'h1},
        '{8'hE2, 16'h1, 16'h0, CL_BRANCH, 1'h0, 1'h1}, '{8'hE1, 16'h3, 16'h40, CL_BRANCH, 1'h1, 1'h1},
        '{8'hE0, 16'h3, 16'h40, CL_BRANCH, 1'h0, 1'h1}, '{8'h70, 16'h0, 16'h800, CL_BRANCH, 1'h1, 1'h0},
        '{8'h71, 16'h0, 16'h800, CL_BRANCH, 1'h0, 1'h0}, '{8'h60, 16'h0, 16'h0, CL_PUSH_ALL, 1'h0, 1'h0},
        '{8'hC8, 16'h0, 16'h0, CL_ENTER, 1'h0, 1'h0}, '{8'h9C, 16'h0, 16'h0, CL_PUSH_FLAGS, 1'h0, 1'h0},
        '{8'hDB, 16'h0, 16'h0, CL_ESCAPE, 1'h0, 1'h0}};
    segment_select_opcode_decode u_dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_DEC(dec), .I_MEM(mem),
        .I_SEG(seg), .I_ALU(alu), .I_BOUND(bnd), .I_FLAGS(flags), .I_COUNT(count), .I_ACCUM(accum),
        .I_INTR(intr), .I_TEST_N(test_n), .O_STALL(stall), .O_SEG_SEL(ssel), .O_PHYS_ADDR(paddr),
        .O_ADDR_VALID(avalid), .O_CLASS(cls), .O_FAR_SEG(far_seg), .O_RESULT(res), .O_BRANCH(br),
        .O_COUNT_NEXT(cnext), .O_COUNT_WE(cwe), .O_REP_AGAIN(rep_again), .O_STR_ELEM(str_elem),
        .O_HALTED(halted), .O_LOCK_N(lock_n), .O_ESC(extension_handoff), .O_TRAP(trap), .O_TRAP_VEC(tvec));
    test_pin_partner u_partner (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_lag(4'h4),
        .o_test_n(test_n));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic issue(input logic [7:0] op);
        @(negedge clk) dec <= '{1'h1, op};
        @(negedge clk) dec <= '0;
    endtask
    task automatic mref(input acc_t k, input logic [15:0] b, d, input logic bp, d8);
        @(negedge clk) mem <= '{1'h1, k, b, 16'h0, d, 1'h1, 1'h0, bp, d8};
        @(negedge clk) mem <= '0;
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        forever #10 clk = ~clk;
    end
    // generous ceiling: the whole sequence needs well under 300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        `CHK("lock_rst", 1'h1, lock_n)
        rst_n <= 1'h1;
        foreach (rows[i]) begin
            count <= rows[i].cnt;
            flags <= rows[i].flg;
            issue(rows[i].op);
            `CHK("class", rows[i].cls, cls)
            `CHK("branch", rows[i].br, br)
            `CHK("count_we", rows[i].we, cwe)
            `CHK("esc", rows[i].cls == CL_ESCAPE, extension_handoff)
            if (rows[i].we) `CHK("count", rows[i].cnt - 16'h1, cnext)
        end
        mref(ACC_DATA, 16'h1234, 16'h0, 1'h1, 1'h0);
        `CHK("addr_bp", {1'h1, SEG_STACK, 20'h21234}, {avalid, ssel, paddr})
        mref(ACC_DATA, 16'h0003, 16'h00FE, 1'h0, 1'h1);
        `CHK("addr_short", {SEG_DATA, 20'h10001}, {ssel, paddr})
        mref(ACC_STACK, 16'h0010, 16'h0, 1'h0, 1'h0);
        `CHK("seg_push", SEG_STACK, ssel)
        mref(ACC_FETCH, 16'h0010, 16'h0, 1'h0, 1'h0);
        `CHK("addr_fetch", 20'h30010, paddr)
        issue(OP_PFX_EXTRA);
        issue(8'h8B);
        mref(ACC_DATA, 16'h0010, 16'h0, 1'h0, 1'h0);
        `CHK("seg_override", SEG_EXTRA, ssel)
        issue(OP_PFX_LOCK);
        issue(8'h90);
        `CHK("lock_on", 1'h0, lock_n)
        issue(8'h90);
        `CHK("lock_off", 1'h1, lock_n)
        issue(OP_HALT);
        `CHK("halted", 1'h1, halted)
        issue(OP_PUSH_ALL);
        `CHK("refused", CL_NONE, cls)
        @(negedge clk) intr <= 1'h1;
        @(negedge clk) intr <= 1'h0;
        `CHK("halt_exit", 1'h0, halted)
        // let the test pin synchroniser drain before the wait starts
        repeat (6) @(negedge clk);
        issue(OP_WAIT);
        n = 0;
        while (stall === 1'h1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        `CHK("wait_len", 2'h2, {n > 4, stall})
        alu <= '{16'hFFFF, 16'h0001};
        flags <= 16'h0801;
        issue(8'h13);
        `CHK("add_carry", 17'h10001, {res.carry, res.data})
        issue(OP_TRAP_OVF);
        `CHK("trap", {1'h1, VEC_OVERFLOW}, {trap, tvec})
        accum <= 16'h8085;
        alu <= '{16'h0001, 16'h0001};
        issue(OP_FAR_EXTRA);
        `CHK("far_seg", SEG_EXTRA, far_seg)
        issue(OP_FLAGS_TO_ACC);
        `CHK("flags_to_acc", {1'h1, 16'h0185, 16'h0801}, {res.we, res.data, res.aux})
        issue(OP_BYTE_WIDEN);
        `CHK("byte_widen", 16'hFF85, res.data)
        issue(OP_WORD_WIDEN);
        `CHK("word_widen", 32'h8085FFFF, {res.data, res.aux})
        issue(8'h1B);
        `CHK("sub_borrow", 17'h1FFFF, {res.carry, res.data})
        issue(8'h1A);
        `CHK("sub_borrow_byte", 17'h100FF, {res.carry, res.data})
        bnd <= '{16'h0009, 16'h0000, 16'h0008};
        issue(OP_BOUND);
        `CHK("bounds_out", {1'h1, VEC_BOUNDS}, {trap, tvec})
        bnd <= '{16'h0008, 16'h0000, 16'h0008};
        issue(OP_BOUND);
        `CHK("bounds_in", 1'h0, trap)
        count <= 16'h0002;
        issue(OP_PFX_REP);
        issue(8'hA4);
        `CHK("rep_first", 19'h70001, {rep_again, str_elem, cwe, cnext})
        count <= 16'h0001;
        issue(8'hA4);
        `CHK("rep_last", 3'h3, {rep_again, str_elem, cwe})
        issue(OP_HALT);
        @(negedge clk) rst_n <= 1'h0;
        @(negedge clk) `CHK("halt_reset", 2'h0, {halted, stall})
        rst_n <= 1'h1;
        close_out();
    end
endmodule
